// *** shared/crx_pkg.sv ***
// Purpose: constants and carrier types for the can receive queue and status block
// Assumes: 8-bit register port, one clock at 50 MHz
// Notes: register offsets are local to this block
package crx_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h00; // can_control_reg: read pointer, mode
	localparam logic [7:0] ADR_STAT = 8'h01; // can_status_reg: interrupt code
	localparam logic [7:0] ADR_ECON = 8'h02; // enhanced_control_reg
	localparam logic [7:0] ADR_COMM = 8'h03; // comm_status_reg
	localparam logic [7:0] ADR_IOCN = 8'h04; // can_io_control_reg
	localparam logic [7:0] ADR_ROLE = 8'h05; // buffer_role_reg
	localparam logic [7:0] ADR_FULL = 8'h06; // rx_full_flag per queue slot, write 0 clears
	localparam logic [7:0] ADR_TXEC = 8'h07; // transmit error counter
	localparam logic [7:0] ADR_RXEC = 8'h08; // receive error counter
	localparam logic [7:0] ADR_IDL0 = 8'h10; // ident low byte of programmable buffer 0..5
	// ------------------------------------------------------------
	// field positions and values
	// ------------------------------------------------------------
	localparam int NQ = 8; // max queue depth
	localparam int NPB = 6; // programmable buffers
	localparam logic [1:0] MODE_LEGACY = 2'h0;
	localparam logic [1:0] MODE_FIFO = 2'h2;
	localparam logic [4:0] CODE_FIFO_RX = 5'h10;
	localparam logic [4:0] CODE_NONE = 5'h00;
	localparam int IO_TS_BIT = 4;
	localparam int ECON_WM_BIT = 5;
	localparam logic [8:0] LIM_PASSIVE = 9'd127;
	localparam logic [8:0] LIM_WARN = 9'd95;
	localparam logic [8:0] LIM_BUSOFF = 9'd255;
	localparam logic [3:0] WM_FOUR = 4'h4;
	localparam logic [3:0] WM_ONE = 4'h1;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// ------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic ext_frame_flag; // extended frame received
		logic rx_remote_req_flag; // remote request of a standard frame
		logic [2:0] std_ident_bits; // sid 2..0 or eid 20..18
		logic [1:0] ext_ident_bits; // eid 17..16
	} crx_msg_t;
	typedef struct packed {
		logic [3:0] rd_ptr;
		logic [3:0] wr_ptr;
		logic [NQ-1:0] full;
		logic [1:0] mode;
		logic [4:0] code;
		logic hw_sel;
		logic ts_en;
		logic [NPB-1:0] role;
		logic [8:0] tx_err;
		logic [8:0] rx_err;
		logic ovf_hi;
		logic ovf_lo;
		logic [NQ-1:0][7:0] idl;
		logic [7:0] rdata;
		logic hw_irq;
		logic ts_strobe;
	} crx_state_t;
endpackage : crx_pkg

// *** design/crx_core.sv ***
// Purpose: receive queue, status bits, ident low bytes and time-stamp strobe
// Assumes: accepted messages arrive as one-cycle pulses from the filter logic
// Notes: queue slots 0,1 are the dedicated buffers, 2..7 the programmable ones
`timescale 1ns/1ps
`default_nettype none
module crx_core
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	// accepted message from the filters
	input wire logic msg_valid,
	input wire crx_pkg::crx_msg_t msg,
	// error counter events
	input wire logic tx_err_inc,
	input wire logic rx_err_inc,
	// outputs toward interrupt logic and capture unit
	output logic queue_hw_irq,
	output logic capture_strobe
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	crx_pkg::crx_state_t s_r; // all state
	crx_pkg::crx_state_t s_nxt; // its next value
	logic [3:0] depth; // live queue depth
	logic [3:0] used; // count of full slots
	logic [7:0] comm; // assembled comm status
	logic [7:0] idl_rd; // ident byte as read
	logic [3:0] ix; // ident byte index
	logic [3:0] slot; // slot addressed by ident access
	logic fifo; // fifo mode
	logic in_idl; // address falls on a programmable ident byte
	// ------------------------------------------------------------
	// combinational helpers
	// ------------------------------------------------------------
	// queue depth: scan for lowest transmit buffer
	always_comb
	begin
		depth = 4'(crx_pkg::NQ);
		for (int i = crx_pkg::NPB - 1; i >= 0; i--)
		begin
			if (s_r.role[i])
			begin
				depth = 4'(i + 2);
			end
		end
	end
	// occupancy count for the watermark
	always_comb
	begin
		used = 4'h0;
		for (int i = 0; i < crx_pkg::NQ; i++)
		begin
			if (s_r.full[i])
			begin
				used = used + 4'h1;
			end
		end
	end
	assign fifo = (s_r.mode == crx_pkg::MODE_FIFO);
	assign ix = 4'(addr - crx_pkg::ADR_IDL0);
	assign slot = ix + 4'h2;
	// full-width range test: the 4-bit index alone would alias 0x20.. onto the ident bytes
	// and let unmapped writes land in a transmit buffer
	assign in_idl = (addr >= crx_pkg::ADR_IDL0) && (addr < crx_pkg::ADR_IDL0 + 8'(crx_pkg::NPB));
	// comm status assembly
	always_comb
	begin
		comm = crx_pkg::RST_BYTE;
		comm[7] = s_r.ovf_hi;
		comm[6] = s_r.ovf_lo;
		comm[5] = (s_r.tx_err > crx_pkg::LIM_BUSOFF);
		comm[4] = (s_r.tx_err > crx_pkg::LIM_PASSIVE);
		comm[3] = (s_r.rx_err > crx_pkg::LIM_PASSIVE);
		comm[2] = (s_r.tx_err > crx_pkg::LIM_WARN);
		comm[1] = (s_r.rx_err > crx_pkg::LIM_WARN) && (s_r.rx_err <= crx_pkg::LIM_PASSIVE);
		comm[0] = comm[2] | comm[1];
	end
	// ident low byte as software sees it
	always_comb
	begin
		idl_rd = s_r.idl[slot[2:0]];
		if (s_r.mode == crx_pkg::MODE_LEGACY || !in_idl)
		begin
			idl_rd = crx_pkg::RST_BYTE;
		end
		else if (s_r.role[ix[2:0]])
		begin
			idl_rd[4] = 1'b0;
			idl_rd[2] = 1'b0;
		end
	end
	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.ts_strobe = 1'b0;
		s_nxt.rdata = crx_pkg::RST_BYTE;
		// error counters saturate rather than wrap
		if (tx_err_inc && s_r.tx_err != 9'h1ff)
		begin
			s_nxt.tx_err = s_r.tx_err + 9'h1;
		end
		if (rx_err_inc && s_r.rx_err != 9'h1ff)
		begin
			s_nxt.rx_err = s_r.rx_err + 9'h1;
		end
		// register writes first so a message in the same cycle wins
		if (wr_stb)
		begin
			case (addr)
				crx_pkg::ADR_CTRL: s_nxt.mode = wdata[7:6];
				crx_pkg::ADR_ECON: s_nxt.hw_sel = wdata[crx_pkg::ECON_WM_BIT];
				crx_pkg::ADR_IOCN: s_nxt.ts_en = wdata[crx_pkg::IO_TS_BIT];
				crx_pkg::ADR_ROLE: s_nxt.role = wdata[crx_pkg::NPB-1:0];
				crx_pkg::ADR_STAT: s_nxt.code = crx_pkg::CODE_NONE;
				crx_pkg::ADR_COMM:
				begin
					// writing zero clears, ones are ignored
					s_nxt.ovf_hi = s_r.ovf_hi & wdata[7];
					s_nxt.ovf_lo = s_r.ovf_lo & wdata[6];
				end
				crx_pkg::ADR_FULL:
				begin
					s_nxt.full = s_r.full & wdata;
					// pointer moves on when its slot is released
					if (s_r.full[s_r.rd_ptr[2:0]] && !wdata[s_r.rd_ptr[2:0]])
					begin
						s_nxt.rd_ptr = (s_r.rd_ptr + 4'h1 >= depth) ? 4'h0 : s_r.rd_ptr + 4'h1;
					end
				end
				default:
				begin
					// transmit-role ident bytes take writes, receive ones are read only
					if (in_idl && s_r.role[ix[2:0]] && s_r.mode != crx_pkg::MODE_LEGACY)
					begin
						s_nxt.idl[slot[2:0]] = wdata & 8'heb;
					end
				end
			endcase
		end
		// message acceptance: any filter, single entry point
		if (msg_valid)
		begin
			if (s_r.ts_en)
			begin
				s_nxt.ts_strobe = 1'b1;
			end
			if (fifo)
			begin
				if (!s_r.full[s_r.wr_ptr[2:0]])
				begin
					s_nxt.full[s_r.wr_ptr[2:0]] = 1'b1;
					s_nxt.idl[s_r.wr_ptr[2:0]] = {msg.std_ident_bits,
						msg.ext_frame_flag | msg.rx_remote_req_flag,
						msg.ext_frame_flag, 1'b0, msg.ext_ident_bits};
					s_nxt.wr_ptr = (s_r.wr_ptr + 4'h1 >= depth) ? 4'h0 : s_r.wr_ptr + 4'h1;
					s_nxt.code = crx_pkg::CODE_FIFO_RX;
				end
				else
				begin
					s_nxt.ovf_lo = 1'b1; // queue overrun
				end
			end
		end
		// queue-not-empty flag in fifo mode
		if (fifo && s_nxt.full[s_nxt.rd_ptr[2:0]])
		begin
			s_nxt.ovf_hi = 1'b1;
		end
		// high-water: four or one empty slot
		s_nxt.hw_irq = fifo && (depth - used == (s_r.hw_sel ? crx_pkg::WM_ONE : crx_pkg::WM_FOUR));
		// read data, one cycle after the strobe
		if (rd_stb)
		begin
			case (addr)
				crx_pkg::ADR_CTRL: s_nxt.rdata = {s_r.mode, 2'h0, s_r.rd_ptr};
				crx_pkg::ADR_STAT: s_nxt.rdata = {3'h0, s_r.code};
				crx_pkg::ADR_ECON: s_nxt.rdata = {2'h0, s_r.hw_sel, 5'h0};
				crx_pkg::ADR_COMM: s_nxt.rdata = comm;
				crx_pkg::ADR_IOCN: s_nxt.rdata = {3'h0, s_r.ts_en, 4'h0};
				crx_pkg::ADR_ROLE: s_nxt.rdata = {2'h0, s_r.role};
				crx_pkg::ADR_FULL: s_nxt.rdata = s_r.full;
				crx_pkg::ADR_TXEC: s_nxt.rdata = s_r.tx_err[7:0];
				crx_pkg::ADR_RXEC: s_nxt.rdata = s_r.rx_err[7:0];
				default: s_nxt.rdata = idl_rd;
			endcase
		end
	end
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end
	assign rdata = s_r.rdata;
	assign queue_hw_irq = s_r.hw_irq;
	assign capture_strobe = s_r.ts_strobe;
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_strobe_follows: assert property (@(posedge clk) disable iff (!rst_n)
		msg_valid && s_r.ts_en |=> capture_strobe) else $error("missing capture strobe");
	chk_strobe_gated: assert property (@(posedge clk) disable iff (!rst_n)
		capture_strobe |-> $past(s_r.ts_en) && $past(msg_valid)) else $error("stray capture strobe");
	chk_code_load: assert property (@(posedge clk) disable iff (!rst_n)
		msg_valid && fifo && !s_r.full[s_r.wr_ptr[2:0]] |=> s_r.code == 5'h10) else $error("code not loaded");
	chk_passive_bit: assert property (@(posedge clk) disable iff (!rst_n)
		comm[3] == (s_r.rx_err > 9'd127)) else $error("rx passive wrong");
	chk_ptr_range: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.rd_ptr < 4'h8 && s_r.wr_ptr < 4'h8) else $error("pointer out of range");
	chk_ptr_advance: assert property (@(posedge clk) disable iff (!rst_n)
		wr_stb && addr == 8'h06 && s_r.full[s_r.rd_ptr[2:0]] && !wdata[s_r.rd_ptr[2:0]]
		|=> s_r.rd_ptr != $past(s_r.rd_ptr)) else $error("pointer stuck");
	chk_warn_or: assert property (@(posedge clk) disable iff (!rst_n)
		comm[0] == (comm[1] | comm[2])) else $error("warning or wrong");
	chk_legacy_ident: assert property (@(posedge clk) disable iff (!rst_n)
		rd_stb && addr >= 8'h10 && s_r.mode == 2'h0 |=> rdata == 8'h00) else $error("ident visible");
	// pending message at the read pointer keeps the not-empty bit up
	chk_empty_flag: assert property (@(posedge clk) disable iff (!rst_n)
		fifo && s_r.full[s_r.rd_ptr[2:0]] && !wr_stb |=> s_r.ovf_hi)
		else $error("not-empty bit missing");
	// overflow bit survives until software clears it
	chk_overflow_keep: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.ovf_lo && !(wr_stb && addr == crx_pkg::ADR_COMM) |=> s_r.ovf_lo)
		else $error("overflow bit lost");
	// upper bit likewise cleared only by a write
	chk_upper_keep: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.ovf_hi && !(wr_stb && addr == crx_pkg::ADR_COMM) |=> s_r.ovf_hi)
		else $error("upper status bit lost");
	// message into a full slot is dropped and flagged
	chk_overrun_flag: assert property (@(posedge clk) disable iff (!rst_n)
		msg_valid && fifo && s_r.full[s_r.wr_ptr[2:0]] |=> s_r.ovf_lo)
		else $error("overrun not flagged");
	// queue never shorter than the two dedicated buffers
	chk_depth_bounds: assert property (@(posedge clk) disable iff (!rst_n)
		depth >= 4'h2 && depth <= 4'h8)
		else $error("depth out of range");
	// first programmable buffer transmitting leaves two slots
	chk_depth_first: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.role[0] |-> depth == 4'h2)
		else $error("depth not two");
	// no transmit buffer gives the full eight
	chk_depth_none: assert property (@(posedge clk) disable iff (!rst_n)
		s_r.role == 6'h00 |-> depth == 4'h8)
		else $error("depth not eight");
	// bus-off bit as read matches the counter
	chk_busoff_read: assert property (@(posedge clk) disable iff (!rst_n)
		rd_stb && addr == crx_pkg::ADR_COMM |=> rdata[5] == ($past(s_r.tx_err) > 9'd255))
		else $error("bus-off bit wrong");
	// transmit warning as read
	chk_tx_warning_read: assert property (@(posedge clk) disable iff (!rst_n)
		rd_stb && addr == crx_pkg::ADR_COMM |=> rdata[2] == ($past(s_r.tx_err) > 9'd95))
		else $error("tx warning wrong");
	// receive warning band as read
	chk_rx_warning_read: assert property (@(posedge clk) disable iff (!rst_n)
		rd_stb && addr == crx_pkg::ADR_COMM |=> rdata[1] == ($past(s_r.rx_err) > 9'd95 && $past(s_r.rx_err) <= 9'd127))
		else $error("rx warning wrong");
	// receive passive as read
	chk_passive_read: assert property (@(posedge clk) disable iff (!rst_n)
		rd_stb && addr == crx_pkg::ADR_COMM |=> rdata[3] == ($past(s_r.rx_err) > 9'd127))
		else $error("rx passive read wrong");
	// unimplemented ident bit always reads zero
	chk_ident_zero: assert property (@(posedge clk) disable iff (!rst_n)
		rd_stb && in_idl |=> !rdata[2])
		else $error("ident bit 2 set");
	// transmit-role ident byte hides bit 4
	chk_tx_bit4: assert property (@(posedge clk) disable iff (!rst_n)
		rd_stb && in_idl && s_r.mode != crx_pkg::MODE_LEGACY && s_r.role[ix[2:0]] |=> !rdata[4])
		else $error("tx ident bit 4 set");
	// receive-role ident bytes ignore writes
	chk_rx_wr_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		wr_stb && in_idl && !s_r.role[ix[2:0]] && !msg_valid |=> s_r.idl == $past(s_r.idl))
		else $error("receive ident written");
	// control read returns the read pointer
	chk_pointer_read: assert property (@(posedge clk) disable iff (!rst_n)
		rd_stb && addr == crx_pkg::ADR_CTRL |=> rdata[3:0] == $past(s_r.rd_ptr))
		else $error("pointer read wrong");
	// every stored message moves the write pointer
	chk_wr_advance: assert property (@(posedge clk) disable iff (!rst_n)
		msg_valid && fifo && !s_r.full[s_r.wr_ptr[2:0]] |=> s_r.wr_ptr != $past(s_r.wr_ptr))
		else $error("write pointer stuck");
	// read pointer wraps at the live depth
	chk_ptr_wrap: assert property (@(posedge clk) disable iff (!rst_n)
		wr_stb && addr == crx_pkg::ADR_FULL && s_r.full[s_r.rd_ptr[2:0]] && !wdata[s_r.rd_ptr[2:0]]
		&& s_r.rd_ptr + 4'h1 >= depth |=> s_r.rd_ptr == 4'h0)
		else $error("pointer did not wrap");
	// outside fifo mode the queue does not fill
	chk_no_store: assert property (@(posedge clk) disable iff (!rst_n)
		msg_valid && !fifo && !wr_stb |=> s_r.full == $past(s_r.full))
		else $error("queue filled outside fifo mode");
	// watermark interrupt belongs to fifo mode only
	chk_irq_fifo: assert property (@(posedge clk) disable iff (!rst_n)
		!fifo |=> !queue_hw_irq)
		else $error("watermark outside fifo");
	// one empty slot with the select bit set raises it
	chk_irq_one: assert property (@(posedge clk) disable iff (!rst_n)
		fifo && s_r.hw_sel && (depth - used == 4'h1) |=> queue_hw_irq)
		else $error("watermark one missing");
	// strobe only follows a message
	chk_strobe_off: assert property (@(posedge clk) disable iff (!rst_n)
		!msg_valid |=> !capture_strobe)
		else $error("strobe without message");
	// ------------------------------------------------------------
	// per-slot checks
	// ------------------------------------------------------------
	// one copy of each slot check per queue entry
	for (genvar g = 0; g < crx_pkg::NQ; g++)
	begin : gen_slot
		// a full slot empties only through a software write
		chk_slot_hold: assert property (@(posedge clk) disable iff (!rst_n)
			s_r.full[g] && !(wr_stb && addr == crx_pkg::ADR_FULL) |=> s_r.full[g])
			else $error("full flag lost");
		// a slot fills only when the write pointer names it
		chk_slot_fill: assert property (@(posedge clk) disable iff (!rst_n)
			!s_r.full[g] && !(msg_valid && fifo && s_r.wr_ptr[2:0] == 3'(g)) |=> !s_r.full[g])
			else $error("slot filled out of turn");
		// stored frame keeps its extended flag in bit 3
		chk_slot_ident: assert property (@(posedge clk) disable iff (!rst_n)
			msg_valid && fifo && !s_r.full[g] && s_r.wr_ptr[2:0] == 3'(g)
			|=> s_r.idl[g][3] == $past(msg.ext_frame_flag))
			else $error("extended flag not stored");
		// bit 4 is one for extended, else the remote request
		chk_slot_remote: assert property (@(posedge clk) disable iff (!rst_n)
			msg_valid && fifo && !s_r.full[g] && s_r.wr_ptr[2:0] == 3'(g)
			|=> s_r.idl[g][4] == $past(msg.ext_frame_flag | msg.rx_remote_req_flag))
			else $error("remote bit not stored");
		// upper three bits carry the low identifier bits
		chk_slot_sid: assert property (@(posedge clk) disable iff (!rst_n)
			msg_valid && fifo && !s_r.full[g] && s_r.wr_ptr[2:0] == 3'(g)
			|=> s_r.idl[g][7:5] == $past(msg.std_ident_bits))
			else $error("identifier bits not stored");
	end : gen_slot
endmodule : crx_core
`default_nettype wire

// *** verif/crx_node.sv ***
// Purpose: far-side node model handing accepted frames to the receive queue
// Assumes: one frame per call, driven just after a rising edge
// Notes: idle fields show the inverse of the last frame, never a held copy
`timescale 1ns/1ps
`default_nettype none
module crx_node
(
	// clock
	input wire logic clk,
	// accepted frame
	output logic msg_valid,
	output crx_pkg::crx_msg_t msg
);
	// idle: nothing offered
	initial
	begin
		msg_valid = 1'b0;
		msg = '0;
	end
	// offer one frame for one cycle; any enabled filter may have taken it
	task automatic send(input crx_pkg::crx_msg_t m);
		@(posedge clk);
		msg_valid <= 1'b1;
		msg <= m;
		@(posedge clk);
		msg_valid <= 1'b0;
		msg <= ~m; // stale fields must not look valid
	endtask : send
endmodule : crx_node
`default_nettype wire

// *** verif/test_can_rx_fifo_status_timestamp.sv ***
// Purpose: self-checking bench for the receive queue and status block
// Assumes: register port with read data one cycle after the strobe
// Notes: every scenario is a task; a gap cycle separates bus strobes
`timescale 1ns/1ps
`default_nettype none
module test_can_rx_fifo_status_timestamp;
	logic clk, rst_n, wr_stb, rd_stb, msg_valid, tx_err_inc, rx_err_inc;
	logic [7:0] addr, wdata, rdata;
	logic queue_hw_irq, capture_strobe;
	crx_pkg::crx_msg_t msg;
	int error_cnt = 0;
	int n_checks = 0;
	crx_core dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata), .msg_valid(msg_valid), .msg(msg),
		.tx_err_inc(tx_err_inc), .rx_err_inc(rx_err_inc),
		.queue_hw_irq(queue_hw_irq), .capture_strobe(capture_strobe));
	crx_node node (.clk(clk), .msg_valid(msg_valid), .msg(msg));
	// 50 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// shared compare
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one-cycle write
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : wr
	// one-cycle read, data judged in the following cycle only
	task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 chk(what, exp, rdata);
	endtask : rd
	// error counter events, one pulse per two cycles
	task pulse(input logic t, input logic r, input int n);
		repeat (n)
		begin
			@(posedge clk);
			tx_err_inc <= t;
			rx_err_inc <= r;
			@(posedge clk);
			tx_err_inc <= 1'b0;
			rx_err_inc <= 1'b0;
		end
	endtask : pulse
	task do_reset();
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
	endtask : do_reset
	// reset values, legacy mode, unmapped place, counter thresholds
	task t_status();
		do_reset();
		rd(crx_pkg::ADR_COMM, 8'h00, "comm reset");
		rd(crx_pkg::ADR_IDL0, 8'h00, "ident in legacy");
		rd(8'h20, 8'h00, "unmapped");
		pulse(1'b1, 1'b1, 96);
		rd(crx_pkg::ADR_COMM, 8'h07, "comm warn");
		pulse(1'b0, 1'b1, 32);
		rd(crx_pkg::ADR_COMM, 8'h0d, "comm passive");
		pulse(1'b1, 1'b0, 160);
		rd(crx_pkg::ADR_COMM, 8'h3d, "comm bus-off");
	endtask : t_status
	// queue fill, ident layout, pointer, high water, time-stamp
	task t_fifo();
		do_reset();
		wr(crx_pkg::ADR_IOCN, 8'h10);
		wr(crx_pkg::ADR_CTRL, 8'h80);
		node.send('{1'b0, 1'b0, 3'h0, 2'h0});
		#1 chk("strobe", 8'h01, {7'h0, capture_strobe});
		rd(crx_pkg::ADR_STAT, {3'h0, crx_pkg::CODE_FIFO_RX}, "code");
		rd(crx_pkg::ADR_FULL, 8'h01, "full one");
		node.send('{1'b0, 1'b0, 3'h1, 2'h0});
		node.send('{1'b1, 1'b0, 3'h5, 2'h2});
		node.send('{1'b0, 1'b1, 3'h3, 2'h1});
		rd(crx_pkg::ADR_IDL0, 8'hba, "ident ext");
		rd(crx_pkg::ADR_IDL0 + 8'h01, 8'h71, "ident std");
		rd(8'h20, 8'h00, "unmapped fifo");
		chk("irq four", 8'h01, {7'h0, queue_hw_irq});
		wr(crx_pkg::ADR_FULL, 8'hfe);
		rd(crx_pkg::ADR_CTRL, 8'h81, "pointer");
		chk("irq five", 8'h00, {7'h0, queue_hw_irq});
		wr(crx_pkg::ADR_ECON, 8'h20);
		repeat (4) node.send('{1'b0, 1'b0, 3'h2, 2'h3});
		rd(crx_pkg::ADR_FULL, 8'hfe, "full wrap");
		chk("irq one", 8'h01, {7'h0, queue_hw_irq});
	endtask : t_fifo
	// short queue ends at the first transmit buffer, overflow clear
	task t_depth();
		do_reset();
		wr(crx_pkg::ADR_CTRL, 8'h80);
		wr(crx_pkg::ADR_ROLE, 8'h01);
		node.send('{1'b0, 1'b0, 3'h6, 2'h1});
		#1 chk("no strobe", 8'h00, {7'h0, capture_strobe});
		repeat (2) node.send('{1'b0, 1'b0, 3'h6, 2'h1});
		rd(crx_pkg::ADR_FULL, 8'h03, "depth two");
		rd(crx_pkg::ADR_COMM, 8'hc0, "overflow");
		wr(crx_pkg::ADR_COMM, 8'h00);
		rd(crx_pkg::ADR_COMM, 8'h80, "overflow clear");
		wr(crx_pkg::ADR_IDL0, 8'hff);
		rd(crx_pkg::ADR_IDL0, 8'heb, "ident tx");
	endtask : t_depth
	task wrap_up();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	// main sequence
	initial
	begin
		{wr_stb, rd_stb, tx_err_inc, rx_err_inc} = 4'h0;
		addr = 8'h00;
		wdata = 8'h00;
		t_status();
		t_fifo();
		t_depth();
		wrap_up();
	end
	// watchdog, far beyond the fewer than a thousand cycles the tests need
	initial
	begin
		#200us;
		error_cnt++;
		wrap_up();
	end
endmodule : test_can_rx_fifo_status_timestamp
`default_nettype wire
